/* File: dwell_timer.sv */
`timescale 1ns/1ps
module dwell_timer
    import seq_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [CYC_W-1:0] period,
    output logic                  tick
);
    // ****************************************
    // Free-running dwell counter
    // ****************************************
    typedef struct packed {
        logic [CYC_W-1:0] cnt;  // Cycles in current dwell
        logic             tick; // End of dwell
    } dwell_state_t;

    dwell_state_t r_reg;
    dwell_state_t r_next;

    // Count with no sweep input at all, so switching drifts against sweeps
    always_comb begin
        r_next = r_reg;
        if (r_reg.cnt >= period - CYC_W'(1)) begin
            r_next.cnt  = '0;
            r_next.tick = 1'b1;
        end else begin
            r_next.cnt  = r_reg.cnt + CYC_W'(1);
            r_next.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tick = r_reg.tick;
endmodule

/* File: edge_sync.sv */
`timescale 1ns/1ps
module edge_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] rise
);
    // ****************************************
    // Two-stage synchroniser and rising edge
    // ****************************************
    typedef struct packed {
        logic [WIDTH-1:0] s1;  // First stage, read by s2 only
        logic [WIDTH-1:0] s2;  // Stable copy
        logic [WIDTH-1:0] s3;  // Previous stable copy
    } sync_state_t;

    sync_state_t r_reg;
    sync_state_t r_next;

    // Shift chain
    always_comb begin
        r_next    = r_reg;
        r_next.s1 = raw;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // One-cycle pulse per rising edge
    assign rise = r_reg.s2 & ~r_reg.s3;
endmodule

/* File: panel_model.sv */
`timescale 1ns/1ps
module panel_model (
    input  wire logic       clk_sys,
    output logic      [7:0] raw
);
    // Buttons, menu key, retrace, delayed done: idle low
    initial raw = 8'h00;
    // One press or sweep event, len cycles high then as long low
    task pulse(input int i, input int len);
        raw[i] <= 1'h1;
        repeat (len) @(posedge clk_sys);
        raw[i] <= 1'h0;
        repeat (len) @(posedge clk_sys);
    endtask
endmodule

/* File: seq_pkg.sv */
package seq_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS    = 20;                      // 50 MHz system clock
    localparam int DWELL_FAST_NS    = 400;                     // Dwell on fast sweep scales
    localparam int DWELL_SLOW_NS    = 1000;                    // Dwell on other sweep scales
    localparam int XY_SWITCH_KHZ    = 2500;                    // Fixed X-Y switching rate
    localparam int XY_PERIOD_NS     = 1000000 / XY_SWITCH_KHZ; // One dwell per switch
    localparam int FAST_SCALE_MIN_US = 2;                      // Fast band, low end per div
    localparam int FAST_SCALE_MAX_US = 20;                     // Fast band, high end per div
    localparam logic [31:0] FAST_SCALE_MIN_NS = 32'(FAST_SCALE_MIN_US * 1000);
    localparam logic [31:0] FAST_SCALE_MAX_NS = 32'(FAST_SCALE_MAX_US * 1000);
    localparam int CYC_W = 8;                                  // Dwell counter width
    localparam logic [CYC_W-1:0] DWELL_FAST_CYC = CYC_W'(DWELL_FAST_NS / CLK_PERIOD_NS);
    localparam logic [CYC_W-1:0] DWELL_SLOW_CYC = CYC_W'(DWELL_SLOW_NS / CLK_PERIOD_NS);
    localparam logic [CYC_W-1:0] XY_CYC         = CYC_W'(XY_PERIOD_NS / CLK_PERIOD_NS);

    // ****************************************
    // Sources, in priority order
    // ****************************************
    localparam int NUM_SRC = 5;                                // Ch1, Ch2, sum, Ch3, Ch4
    localparam logic [NUM_SRC-1:0] SRC_DEFAULT = 5'h01;        // Channel 1 alone

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;         // Mode control
    localparam logic [ADDR_W-1:0] ADDR_SCALE  = 8'h04;         // Sweep time scale, ns/div
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;         // Selection and source
    localparam logic [ADDR_W-1:0] ADDR_MENU   = 8'h0C;         // Last menu entry
    localparam int CTRL_RETRACE_BIT = 0;                       // 1 retrace, 0 timed interleave
    localparam int CTRL_XY_BIT      = 1;                       // X-Y display
    localparam int CTRL_ALT_BIT     = 2;                       // Main/delayed horiz alternate
    localparam int CTRL_DELTA_BIT   = 3;                       // Time delta readout chosen
    localparam int CTRL_DUAL_BIT    = 4;                       // Dual delays, no cursors
    localparam int CTRL_TRIG1_BIT   = 5;                       // Single main trigger source
    localparam int CTRL_INV_BIT     = 6;                       // Channel 2 polarity flip
    localparam int CTRL_EXIT_BIT    = 7;                       // Leave menu, self clearing
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [31:0] SCALE_RESET = 32'h0000_03E8;
    localparam int STAT_SEL_LSB     = 0;
    localparam int STAT_SRC_LSB     = 8;
    localparam int STAT_REF_BIT     = 16;
    localparam int STAT_DELTA_BIT   = 17;
    localparam int STAT_SLAVED_BIT  = 18;
    localparam int STAT_MENU_BIT    = 19;
    localparam int MENU_ENTRY_LSB   = 0;
    localparam int MENU_VALID_BIT   = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axi_rsp_t;

    typedef struct packed {
        logic [NUM_SRC-1:0] src;       // One-hot shown source
        logic [NUM_SRC-1:0] ind;       // Button indicators
        logic               ref_dly;   // Reference delay in use
        logic               delta_dly; // Delta delay in use
        logic               trig_inv;  // Channel 2 trigger inverted
        logic               slaved;    // Slaved delta-time active
        logic               menu;      // Buttons act as menu entries
    } disp_out_t;
endpackage

/* File: vertical_channel_sequencer.sv */
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module vertical_channel_sequencer
    import seq_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               reset,
    input  wire logic [NUM_SRC-1:0] btn_raw,
    input  wire logic               menu_key_raw,
    input  wire logic               retrace_raw,
    input  wire logic               delayed_done_raw,
    input  wire axi_req_t           axi_in,
    output axi_rsp_t                axi_out,
    output disp_out_t               disp
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic              aw_got;     // Write address held
        logic [ADDR_W-1:0] awaddr;     // Held write address
        logic              w_got;      // Write data held
        logic [31:0]       wdata;      // Held write data
        logic [3:0]        wstrb;      // Held byte strobes
        axi_rsp_t          rsp;        // Bus answer flops
        logic [7:0]        ctrl;       // Mode control
        logic [31:0]       scale;      // Sweep time scale
        logic [NUM_SRC-1:0] sel;       // Selected sources
        logic              menu;       // Menu mode
        logic [2:0]        entry;      // Last menu entry
        logic              entry_vld;  // Entry not yet read
        logic [2:0]        cur;        // Shown source index
        logic [CYC_W-1:0]  period;     // Dwell length
        disp_out_t         disp;       // Display outputs
    } seq_state_t;

    seq_state_t r_reg;
    seq_state_t r_next;

    logic [7:0]         pulse;       // Synchronised rising edges
    logic               dwell_tick;  // Dwell expired
    logic               adv;         // Step to next source
    logic [NUM_SRC-1:0] eff;         // Selection with default
    logic               multi;       // More than one source
    logic               fast;        // Scale in fast band
    logic               slaved;      // Slaved delta-time
    logic [2:0]         first;       // First in sequence
    logic [2:0]         second;      // Second in sequence
    logic [31:0]        rd;          // Read data

    // ****************************************
    // Pin synchronisers and dwell timer
    // ****************************************
    edge_sync #(
        .WIDTH(8)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .raw     ({delayed_done_raw, retrace_raw, menu_key_raw, btn_raw}),
        .rise    (pulse)
    );

    dwell_timer u_dwell (
        .clk_sys (clk_sys),
        .reset   (reset),
        .period  (r_reg.period),
        .tick    (dwell_tick)
    );

    // ****************************************
    // Sequence helpers
    // ****************************************
    // Lowest set index, which is highest priority
    function automatic logic [2:0] first_idx(input logic [NUM_SRC-1:0] m);
        logic [2:0] res;
        res = '0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (m[k]) begin
                res = 3'(k);
            end
        end
        return res;
    endfunction

    // Next set index after c, wrapping in priority order
    function automatic logic [2:0] next_idx(input logic [NUM_SRC-1:0] m,
                                            input logic [2:0] c);
        logic [2:0] res;
        int         j;
        res = c;
        j   = 0;
        for (int k = NUM_SRC - 1; k >= 1; k--) begin
            j = (int'(c) + k) % NUM_SRC;
            if (m[j]) begin
                res = 3'(j);
            end
        end
        return res;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        r_next = r_reg;
        rd     = '0;
        // Write answer taken
        if (r_reg.rsp.bvalid && axi_in.bready) begin
            r_next.rsp.bvalid = 1'b0;
        end
        // Address and data in either order
        if (axi_in.awvalid && r_reg.rsp.awready) begin
            r_next.aw_got = 1'b1;
            r_next.awaddr = axi_in.awaddr;
        end
        if (axi_in.wvalid && r_reg.rsp.wready) begin
            r_next.w_got = 1'b1;
            r_next.wdata = axi_in.wdata;
            r_next.wstrb = axi_in.wstrb;
        end
        // Perform write once both halves are held
        if (r_next.aw_got && r_next.w_got) begin
            r_next.aw_got     = 1'b0;
            r_next.w_got      = 1'b0;
            r_next.rsp.bvalid = 1'b1;
            r_next.rsp.bresp  = RESP_OKAY;
            case (r_next.awaddr)
                ADDR_CTRL: begin
                    if (r_next.wstrb[0]) begin
                        r_next.ctrl = r_next.wdata[7:0];
                    end
                end
                ADDR_SCALE: begin
                    for (int b = 0; b < 4; b++) begin
                        if (r_next.wstrb[b]) begin
                            r_next.scale[8*b +: 8] = r_next.wdata[8*b +: 8];
                        end
                    end
                end
                ADDR_STATUS, ADDR_MENU: begin
                    // Read-only, write ignored
                end
                default: begin
                    r_next.rsp.bresp = RESP_SLVERR;
                end
            endcase
        end
        // Read answer taken
        if (r_reg.rsp.rvalid && axi_in.rready) begin
            r_next.rsp.rvalid = 1'b0;
        end
        // Read request
        if (axi_in.arvalid && r_reg.rsp.arready) begin
            r_next.rsp.rvalid = 1'b1;
            r_next.rsp.rresp  = RESP_OKAY;
            case (axi_in.araddr)
                ADDR_CTRL: begin
                    rd[7:0] = r_reg.ctrl;
                end
                ADDR_SCALE: begin
                    rd = r_reg.scale;
                end
                ADDR_STATUS: begin
                    rd[STAT_SEL_LSB +: NUM_SRC] = r_reg.disp.ind;
                    rd[STAT_SRC_LSB +: NUM_SRC] = r_reg.disp.src;
                    rd[STAT_REF_BIT]            = r_reg.disp.ref_dly;
                    rd[STAT_DELTA_BIT]          = r_reg.disp.delta_dly;
                    rd[STAT_SLAVED_BIT]         = r_reg.disp.slaved;
                    rd[STAT_MENU_BIT]           = r_reg.disp.menu;
                end
                ADDR_MENU: begin
                    rd[MENU_ENTRY_LSB +: 3] = r_reg.entry;
                    rd[MENU_VALID_BIT]      = r_reg.entry_vld;
                    r_next.entry_vld        = 1'b0;
                end
                default: begin
                    r_next.rsp.rresp = RESP_SLVERR;
                end
            endcase
            r_next.rsp.rdata = rd;
        end
        r_next.rsp.awready = !r_next.aw_got && !r_next.rsp.bvalid;
        r_next.rsp.wready  = !r_next.w_got && !r_next.rsp.bvalid;
        r_next.rsp.arready = !r_next.rsp.rvalid;

        // Menu exit is self clearing; key press after it wins
        if (r_next.ctrl[CTRL_EXIT_BIT]) begin
            r_next.ctrl[CTRL_EXIT_BIT] = 1'b0;
            r_next.menu                = 1'b0;
        end
        if (pulse[NUM_SRC]) begin
            r_next.menu = 1'b1;
        end
        // Buttons: menu entries or display toggles
        if (r_reg.menu) begin
            if (pulse[NUM_SRC-1:0] != '0) begin
                r_next.entry     = first_idx(pulse[NUM_SRC-1:0]);
                r_next.entry_vld = 1'b1;
            end
        end else begin
            r_next.sel = r_reg.sel ^ pulse[NUM_SRC-1:0];
        end

        // Effective selection and its shape
        eff    = (r_next.sel == '0) ? SRC_DEFAULT : r_next.sel;
        multi  = (eff & (eff - NUM_SRC'(1))) != '0;
        fast   = (r_next.scale >= FAST_SCALE_MIN_NS) && (r_next.scale <= FAST_SCALE_MAX_NS);
        first  = first_idx(eff);
        second = first_idx(eff & ~(NUM_SRC'(1) << first));

        // Dwell choice
        if (r_next.ctrl[CTRL_XY_BIT]) begin
            r_next.period = XY_CYC;
        end else if (fast) begin
            r_next.period = DWELL_FAST_CYC;
        end else begin
            r_next.period = DWELL_SLOW_CYC;
        end

        // Advance event by mode
        if (r_reg.ctrl[CTRL_XY_BIT]) begin
            adv = dwell_tick;
        end else if (r_reg.ctrl[CTRL_RETRACE_BIT]) begin
            if (r_reg.ctrl[CTRL_ALT_BIT]) begin
                adv = pulse[7];
            end else begin
                adv = pulse[6];
            end
        end else begin
            adv = dwell_tick;
        end

        // Shown source
        if (!multi || !eff[r_reg.cur]) begin
            r_next.cur = first;
        end else if (adv) begin
            r_next.cur = next_idx(eff, r_reg.cur);
        end

        // Slaved delta-time and delay assignment
        slaved = r_next.ctrl[CTRL_RETRACE_BIT] && r_next.ctrl[CTRL_DELTA_BIT]
                 && r_next.ctrl[CTRL_DUAL_BIT] && r_next.ctrl[CTRL_TRIG1_BIT]
                 && multi;
        r_next.disp.src       = NUM_SRC'(1) << r_next.cur;
        r_next.disp.ind       = r_next.sel;
        r_next.disp.ref_dly   = !slaved || (r_next.cur != second);
        r_next.disp.delta_dly = !slaved || (r_next.cur != first);
        r_next.disp.trig_inv  = r_next.ctrl[CTRL_INV_BIT];
        r_next.disp.slaved    = slaved;
        r_next.disp.menu      = r_next.menu;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r_reg        <= '0;
            r_reg.ctrl   <= CTRL_RESET;
            r_reg.scale  <= SCALE_RESET;
            r_reg.period <= DWELL_SLOW_CYC;
            r_reg.disp.src       <= SRC_DEFAULT;
            r_reg.disp.ref_dly   <= 1'b1;
            r_reg.disp.delta_dly <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign axi_out = r_reg.rsp;
    assign disp    = r_reg.disp;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic [NUM_SRC-1:0] eff_q;     // Effective selection now
    logic [NUM_SRC-1:0] toggled;   // Expected selection after press
    assign eff_q   = (r_reg.sel == '0) ? SRC_DEFAULT : r_reg.sel;
    assign toggled = r_reg.sel ^ pulse[NUM_SRC-1:0];

    wrap_first_a: assert property (
        adv && (eff_q & ~(NUM_SRC'(2) << r_reg.cur) & ~NUM_SRC'(1) << 0) != '0
        && $stable(r_reg.sel) && r_reg.cur == 3'(NUM_SRC-1) && eff_q[r_reg.cur] && !reset
        |=> r_reg.cur == first_idx(eff_q) || $changed(r_reg.sel))
        else $error("wrap did not return to first source");
    skip_unsel_a: assert property ((r_reg.disp.src & ~eff_q) == '0)
        else $error("unselected source shown");
    fast_dwell_a: assert property (
        !r_reg.ctrl[CTRL_XY_BIT] && fast
        |-> ##1 r_reg.period == DWELL_FAST_CYC || $changed(r_reg.ctrl) || $changed(r_reg.scale))
        else $error("fast dwell not chosen");
    tick_gap_a: assert property (dwell_tick |=> !dwell_tick [*8])
        else $error("dwell ticks too close");
    xy_rate_a: assert property (r_reg.ctrl[CTRL_XY_BIT] |-> r_reg.period == XY_CYC)
        else $error("xy switching rate wrong");
    retrace_only_a: assert property (
        $changed(r_reg.cur) && $stable(r_reg.sel)
        && $past(r_reg.ctrl[CTRL_RETRACE_BIT]) && !$past(r_reg.ctrl[CTRL_XY_BIT])
        && !$past(r_reg.ctrl[CTRL_ALT_BIT]) && $past(eff_q[r_reg.cur]) |-> $past(pulse[6]))
        else $error("retrace step outside retrace");
    delayed_only_a: assert property (
        $changed(r_reg.cur) && $stable(r_reg.sel)
        && $past(r_reg.ctrl[CTRL_RETRACE_BIT]) && !$past(r_reg.ctrl[CTRL_XY_BIT])
        && $past(r_reg.ctrl[CTRL_ALT_BIT]) |-> $past(pulse[7]))
        else $error("step before delayed sweep done");
    delay_split_a: assert property (
        r_reg.disp.slaved && r_reg.cur == first_idx(eff_q)
        |-> r_reg.disp.ref_dly && !r_reg.disp.delta_dly)
        else $error("first source delay wrong");
    slave_cond_a: assert property (
        r_reg.disp.slaved |-> r_reg.ctrl[CTRL_RETRACE_BIT]
        && r_reg.ctrl[CTRL_DELTA_BIT] && r_reg.ctrl[CTRL_DUAL_BIT]
        && r_reg.ctrl[CTRL_TRIG1_BIT] && (eff_q & (eff_q - NUM_SRC'(1))) != '0)
        else $error("slaved mode without conditions");
    trig_inv_a: assert property (r_reg.disp.trig_inv == r_reg.ctrl[CTRL_INV_BIT])
        else $error("trigger polarity not following flip");
    menu_hold_a: assert property (r_reg.menu && pulse[NUM_SRC-1:0] != '0 |=> $stable(r_reg.sel))
        else $error("menu press toggled a display");
    default_ch1_a: assert property (r_reg.sel == '0 |-> r_reg.disp.src == SRC_DEFAULT)
        else $error("default channel 1 not shown");
    toggle_a: assert property (
        !r_reg.menu && pulse[NUM_SRC-1:0] != '0
        |=> r_reg.sel == $past(toggled) ##0 r_reg.disp.ind == r_reg.sel)
        else $error("press did not flip selection");
    single_hold_a: assert property (
        (eff_q & (eff_q - NUM_SRC'(1))) == '0 && $stable(r_reg.sel)
        |-> r_reg.cur == first_idx(eff_q))
        else $error("single source not held");
    // Timed mode steps on the free dwell tick only, never on a sweep event
    timed_free_a: assert property (
        !r_reg.ctrl[CTRL_RETRACE_BIT] && !r_reg.ctrl[CTRL_XY_BIT] && !dwell_tick
        && pulse[NUM_SRC-1:0] == '0 |=> $stable(r_reg.cur))
        else $error("timed step without dwell tick");

    cover_xy_c:     cover property (r_reg.ctrl[CTRL_XY_BIT] && $changed(r_reg.cur));
    cover_retrace_c: cover property (r_reg.ctrl[CTRL_RETRACE_BIT] && $changed(r_reg.cur));
    cover_slaved_c: cover property (r_reg.disp.slaved && !r_reg.disp.ref_dly);
endmodule

/* File: vertical_channel_sequencer_tb_top.sv */
`timescale 1ns/1ps
module vertical_channel_sequencer_tb_top
    import seq_pkg::*;
;
    logic        clk_sys = 1'h0;
    logic        reset   = 1'h1;
    logic [7:0]  raw;
    axi_req_t    axi_in  = '0;
    axi_rsp_t    axi_out;
    disp_out_t   disp;
    int          n_fail = 0, cmp_count = 0, n;
    logic [31:0] rd_data;
    logic [1:0]  resp;
    logic [4:0]  a, b;
    logic [31:0] sc [4] = '{32'h0000_07D0, 32'h0000_4E20, 32'h0000_07CF, 32'h0000_4E21};
    int          dw [4] = '{20, 20, 50, 50};
    always #10 clk_sys = ~clk_sys;
    panel_model panel_model_i (.clk_sys(clk_sys), .raw(raw));
    vertical_channel_sequencer vertical_channel_sequencer_i (
        .clk_sys(clk_sys), .reset(reset), .btn_raw(raw[4:0]), .menu_key_raw(raw[5]),
        .retrace_raw(raw[6]), .delayed_done_raw(raw[7]), .axi_in(axi_in),
        .axi_out(axi_out), .disp(disp));
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    // Bus write, address and data offered together
    task wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_sys);
        axi_in.awaddr  <= ad;
        axi_in.wdata   <= d;
        axi_in.wstrb   <= 4'hF;
        axi_in.awvalid <= 1'h1;
        axi_in.wvalid  <= 1'h1;
        axi_in.bready  <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (axi_out.awready === 1'h1) axi_in.awvalid <= 1'h0;
            if (axi_out.wready === 1'h1) axi_in.wvalid <= 1'h0;
        end while (axi_out.bvalid !== 1'h1);
        axi_in.bready <= 1'h0;
        resp = axi_out.bresp;
    endtask
    // Bus read
    task rd(input logic [7:0] ad);
        @(posedge clk_sys);
        axi_in.araddr  <= ad;
        axi_in.arvalid <= 1'h1;
        axi_in.rready  <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (axi_out.arready === 1'h1) axi_in.arvalid <= 1'h0;
        end while (axi_out.rvalid !== 1'h1);
        axi_in.rready <= 1'h0;
        rd_data = axi_out.rdata;
        resp    = axi_out.rresp;
    endtask
    // Cycles until the shown source changes
    task hold;
        a = disp.src;
        n = 0;
        while (disp.src === a && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        b = disp.src;
    endtask
    function logic [4:0] nx(input logic [4:0] s);
        return (s == 5'h02) ? 5'h08 : 5'h02;
    endfunction
    task end_of_test;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        $display("unexpected at %0t: watchdog", $time);
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'h0;
        chk(disp.src, 1, "default");
        rd(ADDR_SCALE);
        chk(rd_data, 32'h0000_03E8, "scale");
        rd(8'h40);
        chk(resp, RESP_SLVERR, "unmapped");
        wr(8'h40, 32'h0000_0001);
        chk(resp, RESP_SLVERR, "unmapped write");
        panel_model_i.pulse(1, 4);
        panel_model_i.pulse(3, 4);
        panel_model_i.pulse(6, 4);
        repeat (6) @(posedge clk_sys);
        chk(disp.ind, 5'h0A, "toggle");
        hold;
        hold;
        chk(n, 50, "slow dwell");
        chk(b, nx(a), "order");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SCALE, sc[i]);
            hold;
            hold;
            chk(n, dw[i], "band");
        end
        wr(ADDR_CTRL, 32'h0000_0003);
        chk(resp, RESP_OKAY, "write okay");
        hold;
        hold;
        chk(n, 20, "xy");
        $display("timed tests done");
        wr(ADDR_CTRL, 32'h0000_0039);
        repeat (4) @(posedge clk_sys);
        a = disp.src;
        repeat (100) @(posedge clk_sys);
        chk(disp.src, a, "hold");
        chk(disp.slaved, 1, "slaved");
        chk({disp.ref_dly, disp.delta_dly}, (a == 5'h02) ? 2'h2 : 2'h1, "delays");
        panel_model_i.pulse(6, 4);
        chk(disp.src, nx(a), "retrace");
        wr(ADDR_CTRL, 32'h0000_003D);
        a = disp.src;
        panel_model_i.pulse(6, 4);
        chk(disp.src, a, "alt hold");
        panel_model_i.pulse(7, 4);
        chk(disp.src, nx(a), "alt step");
        wr(ADDR_CTRL, 32'h0000_0031);
        repeat (2) @(posedge clk_sys);
        chk(disp.slaved, 0, "no delta");
        $display("retrace tests done");
        wr(ADDR_CTRL, 32'h0000_0040);
        repeat (2) @(posedge clk_sys);
        chk(disp.trig_inv, 1, "flip");
        panel_model_i.pulse(3, 2);
        repeat (6) @(posedge clk_sys);
        repeat (120) @(posedge clk_sys);
        chk(disp.src, 5'h02, "single");
        panel_model_i.pulse(5, 4);
        panel_model_i.pulse(0, 4);
        repeat (4) @(posedge clk_sys);
        chk(disp.menu, 1, "menu");
        chk(disp.ind, 5'h02, "no toggle");
        rd(ADDR_MENU);
        chk(rd_data[8:0], 9'h100, "entry");
        wr(ADDR_CTRL, 32'h0000_0080);
        chk(disp.menu, 0, "menu exit");
        rd(ADDR_CTRL);
        chk(rd_data, 0, "exit clears");
        panel_model_i.pulse(4, 4);
        chk(disp.ind, 5'h12, "ch4 on");
        rd(ADDR_STATUS);
        chk(rd_data[4:0], 5'h12, "status sel");
        hold;
        hold;
        chk(n, 50, "wrap dwell");
        chk(b, (a == 5'h02) ? 5'h10 : 5'h02, "wrap");
        $display("panel tests done");
        end_of_test;
    end
endmodule
